/* File: hw/acx_pkg.sv */
// Constants and carrier types for the alignment exit command handler.
// Assumes a 32-bit APB register port and a 16-bit raw converter feed.
package acx_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_WORD0 = 8'h00; // Command word, 10 words
    localparam logic [7:0] OFS_WORD9 = 8'h24; // Last command word
    localparam logic [7:0] OFS_MSTAT = 8'h28; // Module status word
    localparam logic [7:0] OFS_CH1ST = 8'h2C; // Channel one status
    localparam logic [7:0] OFS_CH2ST = 8'h30; // Channel two status
    localparam logic [7:0] OFS_POS1 = 8'h34; // Channel one position
    localparam logic [7:0] OFS_POS2 = 8'h38; // Channel two position
    localparam logic [7:0] OFS_VEL1 = 8'h3C; // Channel one velocity
    localparam logic [7:0] OFS_VEL2 = 8'h40; // Channel two velocity
    localparam logic [7:0] OFS_CTRL = 8'h44; // Alignment control
    localparam logic [7:0] OFS_NULLV = 8'h48; // Programmed null value
    localparam logic [7:0] OFS_NULLA = 8'h4C; // Reading at null point
    localparam logic [7:0] OFS_MINV = 8'h50; // Programmed minimum value
    localparam logic [7:0] OFS_MINA = 8'h54; // Reading at minimum point
    localparam logic [7:0] OFS_MAXV = 8'h58; // Saved maximum value
    localparam logic [7:0] OFS_MAXA = 8'h5C; // Saved maximum reading
    // Command codes
    localparam logic [15:0] CMD_SET_MAX = 16'h900A; // Set maximum
    localparam logic [15:0] CMD_SAVE = 16'h800E; // Save and exit
    localparam logic [15:0] CMD_ABORT = 16'h800F; // Exit without saving
    localparam logic [11:0] CMD_MEAS = 12'h880; // Enter measurement, /16
    // Bit positions
    localparam int XMIT_BIT = 15; // Transmit bit of word 0
    localparam int MS_INIT = 12; // Module initialised
    localparam int MS_MEAS = 8; // In measurement mode
    localparam int MS_ACK = 7; // Acknowledge
    localparam int CS_CAL = 14; // Channel calibrated
    localparam int CS_CFG = 13; // Channel configured
    localparam int CS_ALN = 12; // Channel aligned
    localparam int CS_FAIL = 11; // Channel failed alignment
    // Error codes
    localparam logic [3:0] ERR_NONE = 4'h0; // Accepted
    localparam logic [3:0] ERR_FMT = 4'h1; // Bad code or nonzero words
    localparam logic [3:0] ERR_RANGE = 4'h2; // Value out of range
    localparam logic [3:0] ERR_DIST = 4'h3; // Too close to another point
    localparam logic [3:0] ERR_SIDE = 4'h4; // Same side of null
    localparam logic [3:0] ERR_MODE = 4'h5; // Not allowed in this mode
    // Limits
    localparam logic [32:0] MAG_LIMIT = 33'h07FFFFFFF; // 2,147,483,647
    localparam logic [32:0] SPAN_LIMIT = 33'h00000FFFF; // 65,535
    localparam logic [32:0] MIN_DIST = 33'h000000064; // 100 counts
    localparam logic signed [15:0] ADC_MAX = 16'sh1FFF; // 8,191
    localparam logic [1:0] METH_TWO_PT = 2'h2; // Two-point linear method
    localparam logic [1:0] METH_TWO_SIDE = 2'h1; // Two-sided symmetric
    // Mode states, one-hot
    typedef enum logic [2:0] {
        MODE_INIT = 3'b001,
        MODE_ALIGN = 3'b010,
        MODE_MEAS = 3'b100
    } acx_mode_t;
    // One alignment point
    typedef struct packed {
        logic set; // Point programmed
        logic [31:0] val; // Sign-magnitude value
        logic [31:0] adc; // Sign-magnitude reading at point
    } acx_point_t;
endpackage : acx_pkg

/* File: hw/acx_handler.sv */
// Alignment exit command handler: APB slave holding the ten command
// words, set-maximum checks, save and abort exits, mode selection.
// Assumes converter readings arrive on the module clock, already synced.
//
// Notes on behaviour
// [RQ1] Set-max is 900A, value in words 1-2
// [RQ2] Maximum within range and 65,535 of null
// [RQ3] Two-point method: within 65,535 of minimum
// [RQ4] Reading must differ 100 counts from points
// [RQ5] Raw reading saturates at 8,191 magnitude
// [RQ6] Acknowledge set, error code in bits 3-0
// [RQ7] Host clears transmit bit after each acknowledge
// [RQ8] Ignore commands until transmit clears; then unacknowledge
// [RQ9] Edits take effect only on exit
// [RQ10] Reset discards unsaved alignment edits
// [RQ11] 800E exits and saves to flash
// [RQ12] Save exit acknowledges, enters highest mode
// [RQ13] 800F exits, discarding pending edits
// [RQ14] Abort: alignment if none aligned, else measure
// [RQ15] Power-up measures if any channel ready; ctrl is still 0 in the init cycle, so power-up enters alignment
// [RQ16] Module status bits 12 and 8
// [RQ17] Channel status bits 14, 13, 12
// [RQ18] Any exit measures whenever either channel aligned
// [RQ19] Exit before all points marks channel failed
// [RQ20] Measurement mode reports position, velocity, status
// [RQ21] 880X enters measurement, low digit enables channels
// [RQ22] Alignment reports raw reading as sign-magnitude
// [RQ23] Non two-point: min and max straddle null
// [RQ24] Rejected set-max keeps earlier maximum
//
// The placing of the registers and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module acx_handler
    import acx_pkg::*;
(
    input wire logic MCLK_I, // 100 MHz clock
    input wire logic SYS_RST_I, // Async reset, active high
    input wire logic PSEL_I, // APB select
    input wire logic PENABLE_I, // APB enable
    input wire logic PWRITE_I, // APB direction
    input wire logic [7:0] PADDR_I, // APB byte address
    input wire logic [31:0] PWDATA_I, // APB write data
    output logic [31:0] PRDATA_O, // APB read data
    output logic PREADY_O, // APB ready
    output logic PSLVERR_O, // APB error, unmapped address
    input wire logic signed [15:0] ADC1_I, // Channel one raw reading
    input wire logic signed [15:0] ADC2_I, // Channel two raw reading
    input wire logic [1:0] ALIGNED_NV_I, // Aligned flags held in flash
    output logic FLASH_SAVE_O, // Pulse: write saved points to flash
    output logic [1:0] CHAN_EN_O // Channels enabled for measuring
);
    // Sign-magnitude to two's complement
    function automatic logic signed [32:0] sm2s(input logic [31:0] v);
        logic signed [32:0] m;
        m = $signed({2'b00, v[30:0]});
        sm2s = v[31] ? -m : m;
    endfunction : sm2s
    // Absolute difference of two values
    function automatic logic [32:0] adiff(input logic signed [32:0] a,
                                          input logic signed [32:0] b);
        logic signed [32:0] d;
        d = a - b;
        adiff = d[32] ? 33'(-d) : 33'(d);
    endfunction : adiff

    acx_mode_t mode; // Operating mode
    acx_mode_t next_mode; // Mode after a command
    logic [15:0] word [10]; // Command output block
    logic ack; // Acknowledge flag
    logic [3:0] err; // Error code of last command
    logic [8:0] ctrl; // Alignment control register
    acx_point_t null_pt; // Null point, pending edit
    acx_point_t min_pt; // Minimum point, pending edit
    acx_point_t max_pt; // Maximum point, pending edit
    acx_point_t max_saved; // Maximum point in effect
    logic [1:0] aligned; // Per-channel aligned flag
    logic [1:0] failed; // Per-channel failed alignment
    logic signed [15:0] sat [2]; // Saturated readings
    logic signed [15:0] prev [2]; // Readings one cycle earlier
    logic [31:0] pos [2]; // Reported positions
    logic [31:0] vel [2]; // Reported velocities
    logic [31:0] msw; // Module status word
    logic [31:0] csw [2]; // Channel status words
    logic xmit; // Transmit bit of word 0
    logic exec; // A command is taken this cycle
    logic rest_zero; // Words 3 to 9 are zero
    logic all_zero; // Words 1 to 9 are zero
    logic [3:0] next_err; // Error code being produced
    logic do_max; // Store maximum point
    logic do_save; // Save exit
    logic do_abort; // Abort exit
    logic do_meas; // Enter measurement
    logic sel; // Channel being aligned
    logic [1:0] meth; // Alignment method
    logic complete; // All points required are set
    logic [1:0] next_aligned; // Aligned flags after an exit
    logic signed [32:0] max_s; // Requested maximum, signed
    logic signed [32:0] adc_s; // Present reading, signed
    logic [31:0] adc_sm; // Registered reading from pos, sign-magnitude
    logic [1:0] ready; // Calibrated, configured and aligned
    logic wr; // APB write strobe
    logic rd_setup; // APB read setup phase
    logic mapped; // Address decodes to a register

    // Raw readings: clamp, keep previous, build reports
    for (genvar c = 0; c < 2; c++) begin : g_chan
        logic signed [15:0] raw; // Selected input
        logic [14:0] mag; // Magnitude of reading
        logic signed [16:0] dv; // Change since last cycle
        assign raw = (c == 0) ? ADC1_I : ADC2_I;
        // Clamp beyond the converter limit
        always_comb begin
            if (raw > ADC_MAX) begin
                sat[c] = ADC_MAX; // RQ5
            end else if (raw < -ADC_MAX) begin
                sat[c] = -ADC_MAX; // RQ5
            end else begin
                sat[c] = raw;
            end
        end
        assign mag = sat[c][15] ? 15'(-sat[c]) : 15'(sat[c]);
        assign dv = 17'(sat[c]) - 17'(prev[c]);
        // Previous reading for velocity
        always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
            if (SYS_RST_I) begin
                prev[c] <= '0;
            end else begin
                prev[c] <= sat[c];
            end
        end
        // Position and velocity in sign-magnitude form
        always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
            if (SYS_RST_I) begin
                pos[c] <= '0;
                vel[c] <= '0;
            end else if (mode == MODE_ALIGN || CHAN_EN_O[c]) begin
                pos[c] <= {sat[c][15], 16'h0000, mag}; // RQ22 RQ20
                vel[c] <= {dv[16], 15'h0000,
                           dv[16] ? 16'(-dv) : 16'(dv)}; // RQ20
            end
        end
        assign ready[c] = ctrl[5 + c] & ctrl[7 + c] & aligned[c]; // RQ17
        assign csw[c] = {17'h00000, ctrl[5 + c], ctrl[7 + c], aligned[c],
                         failed[c], 11'h000}; // RQ17
    end

    assign xmit = word[0][XMIT_BIT];
    assign sel = ctrl[0];
    assign meth = ctrl[2:1];
    assign exec = xmit && !ack && mode != MODE_INIT; // RQ8
    assign max_s = sm2s({word[1], word[2]});
    assign adc_s = 33'(sat[sel]);
    assign adc_sm = pos[sel];
    assign msw = {19'h00000, mode != MODE_INIT, 3'h0, mode == MODE_MEAS,
                  ack, 3'h0, err}; // RQ16 RQ6

    // Zero checks on unused words
    always_comb begin
        rest_zero = 1'b1;
        for (int i = 3; i < 10; i++) begin
            rest_zero = rest_zero & (word[i] == 16'h0000);
        end
        all_zero = rest_zero && word[1] == 16'h0000 && word[2] == 16'h0000;
    end

    // Points required by the chosen method
    always_comb begin
        if (meth == METH_TWO_PT || meth == METH_TWO_SIDE) begin
            complete = min_pt.set && max_pt.set;
        end else begin
            complete = null_pt.set && (min_pt.set || max_pt.set);
        end
    end

    // Command decode and checks
    always_comb begin
        next_err = ERR_NONE;
        do_max = 1'b0;
        do_save = 1'b0;
        do_abort = 1'b0;
        do_meas = 1'b0;
        if (word[0] == CMD_SET_MAX && rest_zero) begin // RQ1
            if (mode != MODE_ALIGN) begin
                next_err = ERR_MODE;
            end else if (adiff(max_s, 33'sh0) > MAG_LIMIT) begin
                next_err = ERR_RANGE; // RQ2
            end else if (null_pt.set &&
                         adiff(max_s, sm2s(null_pt.val)) > SPAN_LIMIT) begin
                next_err = ERR_RANGE; // RQ2
            end else if (meth == METH_TWO_PT && min_pt.set &&
                         adiff(max_s, sm2s(min_pt.val)) > SPAN_LIMIT) begin
                next_err = ERR_RANGE; // RQ3
            end else if ((null_pt.set &&
                          adiff(adc_s, sm2s(null_pt.adc)) < MIN_DIST) ||
                         (min_pt.set &&
                          adiff(adc_s, sm2s(min_pt.adc)) < MIN_DIST)) begin
                next_err = ERR_DIST; // RQ4
            end else if (meth != METH_TWO_PT && null_pt.set && min_pt.set &&
                         ((max_s > sm2s(null_pt.val)) ==
                          (sm2s(min_pt.val) > sm2s(null_pt.val)))) begin
                next_err = ERR_SIDE; // RQ23
            end else begin
                do_max = 1'b1;
            end
        end else if ((word[0] == CMD_SAVE || word[0] == CMD_ABORT) &&
                     all_zero) begin
            if (mode != MODE_ALIGN) begin
                next_err = ERR_MODE;
            end else begin
                do_save = word[0] == CMD_SAVE; // RQ11
                do_abort = word[0] == CMD_ABORT; // RQ13
            end
        end else if (word[0][15:4] == CMD_MEAS && word[0][3:2] == 2'h0 &&
                     all_zero) begin
            if (ready == 2'b00) begin
                next_err = ERR_MODE;
            end else begin
                do_meas = 1'b1; // RQ21
            end
        end else begin
            next_err = ERR_FMT;
        end
    end

    // Aligned flags and mode after an exit
    always_comb begin
        next_aligned = aligned;
        if (do_save) begin
            next_aligned[sel] = complete;
        end
        next_mode = mode;
        if (do_save || do_abort) begin
            next_mode = (next_aligned != 2'b00) ? MODE_MEAS
                                               : MODE_ALIGN; // RQ12 RQ14 RQ18
        end else if (do_meas) begin
            next_mode = MODE_MEAS; // RQ21
        end
    end

    // Acknowledge and error code
    always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            ack <= 1'b0;
            err <= ERR_NONE;
        end else if (exec) begin
            ack <= 1'b1; // RQ6
            err <= next_err; // RQ6
        end else if (!xmit) begin
            ack <= 1'b0; // RQ8 RQ7
        end
    end

    // Mode, aligned flags, flash capture after reset release
    always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            mode <= MODE_INIT;
            aligned <= 2'b00;
            failed <= 2'b00;
            CHAN_EN_O <= 2'b00;
            FLASH_SAVE_O <= 1'b0;
        end else begin
            FLASH_SAVE_O <= exec && do_save; // RQ11
            case (mode)
                MODE_INIT: begin
                    aligned <= ALIGNED_NV_I;
                    mode <= ((ALIGNED_NV_I & ctrl[6:5] & ctrl[8:7]) != 2'b00)
                            ? MODE_MEAS : MODE_ALIGN; // RQ15
                end
                MODE_ALIGN, MODE_MEAS: begin
                    if (exec) begin
                        mode <= next_mode;
                        aligned <= next_aligned;
                        if (do_save || do_abort) begin
                            failed[sel] <= !complete; // RQ19
                        end
                        if (do_meas) begin
                            CHAN_EN_O <= word[0][1:0]; // RQ21
                        end
                    end
                end
                default: begin
                    mode <= MODE_INIT;
                end
            endcase
        end
    end

    // Pending and saved maximum point
    always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            max_pt <= '0; // RQ10
            max_saved <= '0;
        end else if (exec && do_max) begin
            max_pt <= {1'b1, word[1], word[2], adc_sm}; // RQ24
        end else if (exec && do_save) begin
            max_saved <= max_pt; // RQ9
            max_pt <= '0;
        end else if (exec && do_abort) begin
            max_pt <= '0; // RQ13
        end
    end

    // APB decode; zero wait states
    assign wr = PSEL_I && PENABLE_I && PWRITE_I;
    assign rd_setup = PSEL_I && !PENABLE_I && !PWRITE_I;
    assign mapped = PADDR_I[1:0] == 2'b00 && PADDR_I <= OFS_MAXA;
    assign PREADY_O = 1'b1;
    assign PSLVERR_O = PSEL_I && PENABLE_I && !mapped;

    // Command words, control and other points
    always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            for (int i = 0; i < 10; i++) begin
                word[i] <= 16'h0000;
            end
            ctrl <= '0;
            null_pt <= '0; // RQ10
            min_pt <= '0; // RQ10
        end else begin
            if (wr && mapped && PADDR_I <= OFS_WORD9) begin
                word[PADDR_I[5:2]] <= PWDATA_I[15:0];
            end
            if (wr && PADDR_I == OFS_CTRL) begin
                ctrl <= PWDATA_I[8:0];
            end
            if (exec && do_abort) begin
                null_pt.set <= 1'b0; // RQ13
                min_pt.set <= 1'b0; // RQ13
            end else begin
                if (wr && PADDR_I == OFS_NULLV) begin
                    null_pt <= {1'b1, PWDATA_I, null_pt.adc};
                end
                if (wr && PADDR_I == OFS_NULLA) begin
                    null_pt.adc <= PWDATA_I;
                end
                if (wr && PADDR_I == OFS_MINV) begin
                    min_pt <= {1'b1, PWDATA_I, min_pt.adc};
                end
                if (wr && PADDR_I == OFS_MINA) begin
                    min_pt.adc <= PWDATA_I;
                end
            end
        end
    end

    // Read data captured in the setup phase
    always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            PRDATA_O <= '0;
        end else if (rd_setup) begin
            case (PADDR_I)
                OFS_MSTAT: PRDATA_O <= msw; // RQ16
                OFS_CH1ST: PRDATA_O <= csw[0];
                OFS_CH2ST: PRDATA_O <= csw[1];
                OFS_POS1: PRDATA_O <= pos[0];
                OFS_POS2: PRDATA_O <= pos[1];
                OFS_VEL1: PRDATA_O <= vel[0];
                OFS_VEL2: PRDATA_O <= vel[1];
                OFS_CTRL: PRDATA_O <= {23'h000000, ctrl};
                OFS_NULLV: PRDATA_O <= null_pt.val;
                OFS_NULLA: PRDATA_O <= null_pt.adc;
                OFS_MINV: PRDATA_O <= min_pt.val;
                OFS_MINA: PRDATA_O <= min_pt.adc;
                OFS_MAXV: PRDATA_O <= max_saved.val;
                OFS_MAXA: PRDATA_O <= max_saved.adc;
                default: begin
                    PRDATA_O <= (mapped && PADDR_I <= OFS_WORD9)
                                ? {16'h0000, word[PADDR_I[5:2]]} : '0;
                end
            endcase
        end
    end

    // Checks
    a_ack_release: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
        ack && !xmit |=> !ack) else $error("ack stayed after xmit clear"); // RQ8
    a_ack_hold: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
        ack && xmit |=> ack && $stable(err))
        else $error("command taken while ack set"); // RQ8
    a_ack_answer: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
        exec |=> ack && err == $past(next_err))
        else $error("no acknowledge"); // RQ6
    a_reading_clamp: assert property (@(posedge MCLK_I)
        disable iff (SYS_RST_I)
        sat[0] <= ADC_MAX && sat[0] >= -ADC_MAX)
        else $error("reading not clamped"); // RQ5
    a_max_kept: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
        exec && word[0] == CMD_SET_MAX && next_err != ERR_NONE
        |=> $stable(max_pt)) else $error("rejected max stored"); // RQ24
    a_saved_stable: assert property (@(posedge MCLK_I)
        disable iff (SYS_RST_I)
        !(exec && do_save) |=> $stable(max_saved))
        else $error("edit applied without exit"); // RQ9
    a_exit_mode: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
        exec && (do_save || do_abort) |=>
        (mode == MODE_MEAS) == (aligned != 2'b00))
        else $error("wrong mode after exit"); // RQ18
    a_fail_mark: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
        exec && do_abort && !complete |=> failed[$past(sel)])
        else $error("incomplete exit not failed"); // RQ19
    a_meas_flag: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
        msw[MS_MEAS] == (mode == MODE_MEAS) && msw[MS_ACK] == ack)
        else $error("status word wrong"); // RQ16
endmodule : acx_handler
`default_nettype wire

/* File: tb/acx_host.sv */
// Host model: an APB master that sends whole command blocks.
// Assumes the slave answers with pready, after any number of waits.
`timescale 1ns/1ps
`default_nettype none
module acx_host
    import acx_pkg::*;
(
    input wire logic clk_i, // Module clock
    output logic psel_o, // APB select
    output logic penable_o, // APB enable
    output logic pwrite_o, // APB direction
    output logic [7:0] paddr_o, // APB address
    output logic [31:0] pwdata_o, // APB write data
    input wire logic [31:0] prdata_i, // APB read data
    input wire logic pready_i, // APB ready
    input wire logic pslverr_i, // APB error
    output logic got_o, // Checked result valid, one cycle
    output logic [32:0] got_data_o // Error flag and read data
);
    // Idle bus at time zero
    initial begin
        {psel_o, penable_o, pwrite_o, paddr_o, pwdata_o} = '0;
        {got_o, got_data_o} = '0;
    end
    // One transfer; the request holds until pready is seen high
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
              input logic chk);
        @(posedge clk_i);
        {psel_o, penable_o, pwrite_o, paddr_o, pwdata_o} <= {2'b10, w, a, d};
        @(posedge clk_i);
        penable_o <= 1'b1;
        do @(posedge clk_i); while (pready_i !== 1'b1);
        got_data_o <= {pslverr_i, prdata_i};
        got_o <= chk;
        // Released data no longer shows the old value
        {psel_o, penable_o, pwdata_o} <= {2'b00, ~d};
        @(posedge clk_i);
        got_o <= 1'b0;
    endtask : xfer
    // Whole command: words 9..1 first, word 0 last, then handshake
    task cmd(input logic [15:0] c, input logic [31:0] v);
        for (int i = 9; i > 0; i--)
            xfer(1'b1, 8'(i * 4), (i == 1) ? {16'h0, v[31:16]} :
                 (i == 2) ? {16'h0, v[15:0]} : 32'h0, 1'b0);
        xfer(1'b1, OFS_WORD0, {16'h0, c}, 1'b0);
        do xfer(1'b0, OFS_MSTAT, 32'h0, 1'b0);
        while (got_data_o[MS_ACK] !== 1'b1);
        xfer(1'b0, OFS_MSTAT, 32'h0, 1'b1);
        xfer(1'b1, OFS_WORD0, 32'h0, 1'b0);
        do xfer(1'b0, OFS_MSTAT, 32'h0, 1'b0);
        while (got_data_o[MS_ACK] !== 1'b0);
    endtask : cmd
endmodule : acx_host
`default_nettype wire

/* File: tb/acx_handler_tb_top.sv */
// Testbench top: host model drives the handler, results checked in order.
// Assumes the zero-wait APB slave and handshake timing of the handler.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin failures++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module acx_handler_tb_top;
    import acx_pkg::*;
    logic clk, rst, psel, pen, pwr, slverr, ready, fsave, got; // Wires
    logic [7:0] paddr; // Address
    logic [31:0] pwdata, prdata; // Data
    logic [32:0] rd; // Result
    logic signed [15:0] adc1, adc2; // Readings
    logic [1:0] nv, chen; // Flash flags, enables
    logic [32:0] expq[$]; // Expected results
    logic [32:0] expv; // Oldest expected result
    logic [31:0] mx; // Accepted maximum value
    int failures = 0, tests_run = 0, seed = 4, pulses = 0; // Counters
    acx_handler dut (.MCLK_I(clk), .SYS_RST_I(rst), .PSEL_I(psel),
        .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr),
        .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(ready),
        .PSLVERR_O(slverr), .ADC1_I(adc1), .ADC2_I(adc2),
        .ALIGNED_NV_I(nv), .FLASH_SAVE_O(fsave), .CHAN_EN_O(chen));
    acx_host host (.clk_i(clk), .psel_o(psel), .penable_o(pen),
        .pwrite_o(pwr), .paddr_o(paddr), .pwdata_o(pwdata),
        .prdata_i(prdata), .pready_i(ready), .pslverr_i(slverr),
        .got_o(got), .got_data_o(rd));
    // Clock, 10 ns period
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Oldest note against each result
    always @(posedge clk) begin
        if (got === 1'b1) begin
            expv = expq.pop_front();
            `CHK(rd, expv)
        end
    end
    // Save pulses seen
    always @(posedge clk) if (fsave === 1'b1) pulses++;
    // Random channel two reading
    always @(posedge clk) adc2 <= 16'($random(seed));
    // Checked read
    task exp_rd(input logic [7:0] a, input logic [32:0] e);
        expq.push_back(e);
        host.xfer(1'b0, a, 32'h0, 1'b1);
    endtask : exp_rd
    // Command with expected status at acknowledge
    task exp_cmd(input logic [15:0] c, input logic [31:0] v,
                 input logic [31:0] e);
        expq.push_back({1'b0, e});
        host.cmd(c, v);
    endtask : exp_cmd
    // Reading change, then let it settle
    task set_adc(input logic signed [15:0] v);
        adc1 <= v;
        repeat (3) @(posedge clk);
    endtask : set_adc
    // Verdict and end of run
    task test_done;
        $display("failures=%0d tests_run=%0d", failures, tests_run);
        if (failures == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : test_done
    // Hang guard
    initial begin
        #100us;
        failures++;
        test_done;
    end
    // Main sequence
    initial begin
        {rst, nv, adc1} = {1'b1, 2'b00, 16'h0000};
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        host.xfer(1'b1, OFS_CTRL, 32'h1E0, 1'b0);
        exp_rd(OFS_MSTAT, 33'h1000);
        exp_rd(8'h60, 33'h100000000);
        exp_cmd(CMD_ABORT, 32'h0, 32'h1080);
        set_adc(16'sd20000);
        exp_rd(OFS_POS1, 33'h1FFF);
        set_adc(-16'sd20000);
        exp_rd(OFS_POS1, 33'h80001FFF);
        set_adc(16'sd0);
        host.xfer(1'b1, OFS_NULLV, 32'h5, 1'b0);
        set_adc(16'sd50);
        exp_cmd(CMD_SET_MAX, 32'd1000, {28'h108, ERR_DIST});
        set_adc(16'sd200);
        exp_cmd(CMD_SET_MAX, 32'd70000, {28'h108, ERR_RANGE});
        mx = 100 + ($random(seed) & 1023);
        exp_cmd(CMD_SET_MAX, mx, 32'h1080);
        exp_cmd(CMD_SET_MAX, 32'd70000, {28'h108, ERR_RANGE});
        exp_rd(OFS_MAXV, 33'h0);
        exp_cmd(CMD_SAVE, 32'h0, 32'h1180);
        exp_rd(OFS_MAXV, {1'b0, mx});
        exp_rd(OFS_MAXA, 33'h0C8);
        `CHK(pulses, 1)
        exp_rd(OFS_CH1ST, 33'h7000);
        for (int i = 1; i < 4; i++) begin
            exp_cmd({CMD_MEAS, 4'(i)}, 32'h0, 32'h1180);
            `CHK(chen, 2'(i))
        end
        rst <= 1'b1;
        nv <= 2'b01;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        exp_rd(OFS_NULLV, 33'h0);
        host.xfer(1'b1, OFS_CTRL, 32'h1, 1'b0);
        host.xfer(1'b1, OFS_NULLV, 32'h5, 1'b0);
        exp_cmd(CMD_ABORT, 32'h0, 32'h1180);
        exp_rd(OFS_CH2ST, 33'h0800);
        repeat (3) @(posedge clk);
        test_done;
    end
endmodule : acx_handler_tb_top
`default_nettype wire
